// ==== rtl/spims_pkg.sv ====
package spims_pkg;
    // register bus
    localparam int         WB_AW           = 4;
    localparam logic [3:0] CTRL_OFS        = 4'h0;
    localparam logic [3:0] STAT_OFS        = 4'h4;
    localparam logic [3:0] DATA_OFS        = 4'h8;
    // control field positions
    localparam int         CTRL_EN_BIT     = 0;
    localparam int         CTRL_MASTER_SELECT_BIT_BIT   = 1;
    localparam int         CTRL_LSB_BIT    = 2;
    localparam int         CTRL_RATE_BIT   = 3;
    localparam int         CTRL_IRQEN_BIT  = 5;
    localparam int         CTRL_DBL_BIT    = 6;
    localparam int         CTRL_SSOUT_BIT  = 7;
    localparam int         CTRL_SSOE_BIT   = 8;
    localparam int         CTRL_W          = 9;
    localparam logic [8:0] CTRL_RESET      = 9'h000;
    // status field positions
    localparam int         STAT_DONE_BIT   = 0;
    localparam int         STAT_WCOL_BIT   = 1;
    localparam int         STAT_BUSY_BIT   = 2;
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    // sck half periods in ref_clk cycles: dividers 4,16,64,128 and doubled 2,8,32,64
    localparam logic [6:0] HALF_R0         = 7'h02;
    localparam logic [6:0] HALF_R1         = 7'h08;
    localparam logic [6:0] HALF_R2         = 7'h20;
    localparam logic [6:0] HALF_R3         = 7'h40;
    localparam logic [6:0] HALF_D0         = 7'h01;
    localparam logic [6:0] HALF_D1         = 7'h04;
    localparam logic [6:0] HALF_D2         = 7'h10;
    localparam logic [6:0] HALF_D3         = 7'h20;
    localparam logic [6:0] REM_HALF        = 7'h08;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    // synchroniser reset levels {ss_n, sck, mosi, miso}: sck idles low
    localparam logic [3:0] PIN_IDLE        = 4'hB;

    typedef enum logic [0:0] {
        SPIMS_IDLE = 1'b0,
        SPIMS_RUN  = 1'b1
    } spims_state_t;
endpackage

// ==== rtl/spims_if.sv ====
`timescale 1ns/10ps
interface spims_if;
    logic dev_sck_o;
    logic dev_sck_oe;
    logic dev_mosi_o;
    logic dev_mosi_oe;
    logic dev_miso_o;
    logic dev_miso_oe;
    logic dev_ss_o;
    logic dev_ss_oe;
    logic rem_sck_o;
    logic rem_sck_oe;
    logic rem_mosi_o;
    logic rem_mosi_oe;
    logic rem_miso_o;
    logic rem_miso_oe;
    logic rem_ss_o;
    logic rem_ss_oe;
    wire  sck;
    wire  mosi;
    wire  miso;
    wire  ss_n;

    // wire levels from the enables; undriven lines float high, except sck which floats low
    assign sck  = dev_sck_oe  ? dev_sck_o  : (rem_sck_oe  ? rem_sck_o  : 1'b0);
    assign mosi = dev_mosi_oe ? dev_mosi_o : (rem_mosi_oe ? rem_mosi_o : 1'b1);
    assign miso = dev_miso_oe ? dev_miso_o : (rem_miso_oe ? rem_miso_o : 1'b1);
    assign ss_n = dev_ss_oe   ? dev_ss_o   : (rem_ss_oe   ? rem_ss_o   : 1'b1);

    modport dev (
        output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
        output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
        input  sck, mosi, miso, ss_n
    );
    modport rem (
        output rem_sck_o, rem_sck_oe, rem_mosi_o, rem_mosi_oe,
        output rem_miso_o, rem_miso_oe, rem_ss_o, rem_ss_oe,
        input  sck, mosi, miso, ss_n
    );
endinterface

// ==== rtl/spims_sync.sv ====
`timescale 1ns/10ps
module spims_sync #(
    parameter int            W    = 4,
    parameter logic [W-1:0]  INIT = '1
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // two flops per pin, first one read only by the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_reg <= INIT;
            q        <= INIT;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ==== rtl/spims_device.sv ====
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module spims_device (
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    spims_if.dev                              spi,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [spims_pkg::WB_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    output logic                              irq_o
);
    import spims_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [3:0]         pin_s;
    logic [CTRL_W-1:0]  ctrl_reg;
    logic [CTRL_W-1:0]  ctrl_next;
    logic               done_reg;
    logic               wcol_reg;
    logic [7:0]         shift_reg;
    logic               samp_reg;
    logic [2:0]         bit_reg;
    logic               active_reg;
    logic [7:0]         rx_reg;
    logic [6:0]         half_cnt_reg;
    logic [6:0]         half_next;
    logic               sck_reg;
    logic               sck_d_reg;
    spims_state_t       state_reg;
    spims_state_t       state_next;

    spims_sync #(.W(4), .INIT(PIN_IDLE)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       ({spi.ss_n, spi.sck, spi.mosi, spi.miso}),
        .q       (pin_s)
    );

    wire ss_s   = pin_s[3];
    wire sck_s  = pin_s[2];
    wire mosi_s = pin_s[1];
    wire miso_s = pin_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire       en        = ctrl_reg[CTRL_EN_BIT];
    wire       is_master = en & ctrl_reg[CTRL_MASTER_SELECT_BIT_BIT];
    wire       is_slave  = en & ~ctrl_reg[CTRL_MASTER_SELECT_BIT_BIT];
    wire       lsb_first = ctrl_reg[CTRL_LSB_BIT];
    wire [1:0] rate      = ctrl_reg[CTRL_RATE_BIT +: 2];
    wire       dbl       = ctrl_reg[CTRL_DBL_BIT];
    wire [6:0] half_norm = (rate == 2'h0) ? HALF_R0 : (rate == 2'h1) ? HALF_R1 :
                           (rate == 2'h2) ? HALF_R2 : HALF_R3;
    wire [6:0] half_dbl  = (rate == 2'h0) ? HALF_D0 : (rate == 2'h1) ? HALF_D1 :
                           (rate == 2'h2) ? HALF_D2 : HALF_D3;
    wire [6:0] half      = dbl ? half_dbl : half_norm;

    wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr       = wb_req & wb_we_i;
    wire wr_ctrl  = wr & (wb_adr_i == CTRL_OFS);
    wire wr_data  = wr & (wb_adr_i == DATA_OFS) & wb_sel_i[0];
    wire rd_data  = wb_req & ~wb_we_i & (wb_adr_i == DATA_OFS);
    wire running  = (state_reg == SPIMS_RUN);
    wire busy     = running | active_reg;
    wire load_ok  = wr_data & ~busy & en;
    wire wcol_set = wr_data & busy;
    wire start    = load_ok & is_master;
    wire fault    = is_master & ~ctrl_reg[CTRL_SSOE_BIT] & ~ss_s;
    wire sel      = is_slave & ~ss_s;

    wire m_tick = running & (half_cnt_reg == 7'h01);
    wire m_rise = m_tick & ~sck_reg;
    wire m_fall = m_tick & sck_reg;
    wire s_rise = sel & sck_s & ~sck_d_reg;
    wire s_fall = sel & ~sck_s & sck_d_reg;
    wire rise   = m_rise | s_rise;
    wire fall   = m_fall | s_fall;
    wire in_bit = is_master ? miso_s : mosi_s;
    wire out_bit = lsb_first ? shift_reg[0] : shift_reg[7];
    wire [7:0] shifted = lsb_first ? {samp_reg, shift_reg[7:1]} : {shift_reg[6:0], samp_reg};
    wire last   = fall & (bit_reg == BIT_LAST);
    wire done_next = last | fault | (done_reg & ~rd_data);
    wire wcol_next = wcol_set | (wcol_reg & ~rd_data);

    wire [CTRL_W-1:0] ctrl_wr = {wb_sel_i[1] ? wb_dat_i[8] : ctrl_reg[8],
                                 wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_reg[7:0]};
    wire [31:0] rd_val = (wb_adr_i == CTRL_OFS) ? {23'h000000, ctrl_reg} :
                         (wb_adr_i == STAT_OFS) ? {29'h00000000, busy, wcol_reg, done_reg} :
                         (wb_adr_i == DATA_OFS) ? {24'h000000, rx_reg} : 32'h00000000;

    always_comb begin
        ctrl_next = wr_ctrl ? ctrl_wr : ctrl_reg;
        if (fault) begin
            ctrl_next[CTRL_MASTER_SELECT_BIT_BIT] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // master clock generator
    always_comb begin
        state_next = state_reg;
        half_next  = half_cnt_reg;
        unique case (state_reg)
            SPIMS_IDLE: begin
                if (start) begin
                    state_next = SPIMS_RUN;
                    half_next  = half;
                end
            end
            SPIMS_RUN: begin
                half_next = m_tick ? half : 7'(half_cnt_reg - 7'h01);
                if (last) begin
                    state_next = SPIMS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset | ~is_master) begin
            state_reg    <= SPIMS_IDLE;
            half_cnt_reg <= 7'h00;
            sck_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            half_cnt_reg <= half_next;
            sck_reg      <= m_tick ? ~sck_reg : sck_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift engine, free running on ref_clk so it works while the cpu idles
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_reg <= BYTE_RESET;
            samp_reg  <= 1'b0;
            sck_d_reg <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            if (load_ok) begin
                shift_reg <= wb_dat_i[7:0];
            end else if (fall) begin
                shift_reg <= shifted;
            end
            if (rise) begin
                samp_reg <= in_bit;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset | ~en | fault | (is_slave & ss_s)) begin
            bit_reg    <= 3'h0;
            active_reg <= 1'b0;
        end else begin
            bit_reg    <= fall ? bit_reg + 3'h1 : bit_reg;
            active_reg <= last ? 1'b0 : (rise | active_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and flags, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
            done_reg <= 1'b0;
            wcol_reg <= 1'b0;
            rx_reg   <= BYTE_RESET;
            irq_o    <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ctrl_reg <= ctrl_next;
            done_reg <= done_next;
            wcol_reg <= wcol_next;
            rx_reg   <= last ? shifted : rx_reg;
            irq_o    <= done_next & ctrl_next[CTRL_IRQEN_BIT];
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_val : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers; select is an ordinary software output in master mode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            spi.dev_sck_o   <= 1'b0;
            spi.dev_sck_oe  <= 1'b0;
            spi.dev_mosi_o  <= 1'b1;
            spi.dev_mosi_oe <= 1'b0;
            spi.dev_miso_o  <= 1'b1;
            spi.dev_miso_oe <= 1'b0;
            spi.dev_ss_o    <= 1'b1;
            spi.dev_ss_oe   <= 1'b0;
        end else begin
            spi.dev_sck_o   <= sck_reg;
            spi.dev_sck_oe  <= is_master;
            spi.dev_mosi_o  <= out_bit;
            spi.dev_mosi_oe <= is_master;
            spi.dev_miso_o  <= out_bit;
            spi.dev_miso_oe <= sel;
            spi.dev_ss_o    <= ctrl_reg[CTRL_SSOUT_BIT];
            spi.dev_ss_oe   <= is_master & ctrl_reg[CTRL_SSOE_BIT];
        end
    end
endmodule

// ==== rtl/spims_remote.sv ====
`timescale 1ns/10ps
module spims_remote (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    spims_if.rem            spi,
    input  wire logic       master_mode,
    input  wire logic       lsb_first,
    input  wire logic       sel_n_req,
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    output logic            busy_o,
    output logic            done_o,
    output logic [7:0]      rx_byte_o
);
    import spims_pkg::*;

    logic [3:0]   pin_s;
    logic [7:0]   shift_reg;
    logic         samp_reg;
    logic [2:0]   bit_reg;
    logic         active_reg;
    logic [6:0]   half_cnt_reg;
    logic         sck_reg;
    logic         sck_d_reg;
    spims_state_t state_reg;
    spims_state_t state_next;

    spims_sync #(.W(4), .INIT(PIN_IDLE)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       ({spi.ss_n, spi.sck, spi.mosi, spi.miso}),
        .q       (pin_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire running = (state_reg == SPIMS_RUN);
    wire sel     = ~master_mode & ~pin_s[3];
    wire load_ok = start & ~running & ~active_reg;
    wire m_tick  = running & (half_cnt_reg == 7'h01);
    wire rise    = (m_tick & ~sck_reg) | (sel & pin_s[2] & ~sck_d_reg);
    wire fall    = (m_tick & sck_reg) | (sel & ~pin_s[2] & sck_d_reg);
    wire in_bit  = master_mode ? pin_s[0] : pin_s[1];
    wire out_bit = lsb_first ? shift_reg[0] : shift_reg[7];
    wire [7:0] shifted = lsb_first ? {samp_reg, shift_reg[7:1]} : {shift_reg[6:0], samp_reg};
    wire last    = fall & (bit_reg == BIT_LAST);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SPIMS_IDLE: state_next = (load_ok & master_mode) ? SPIMS_RUN : SPIMS_IDLE;
            SPIMS_RUN:  state_next = last ? SPIMS_IDLE : SPIMS_RUN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock generator and shifter
    always_ff @(posedge ref_clk) begin
        if (reset | ~master_mode) begin
            state_reg    <= SPIMS_IDLE;
            half_cnt_reg <= REM_HALF;
            sck_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            half_cnt_reg <= (m_tick | ~running) ? REM_HALF : 7'(half_cnt_reg - 7'h01);
            sck_reg      <= m_tick ? ~sck_reg : sck_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_reg <= BYTE_RESET;
            samp_reg  <= 1'b0;
            sck_d_reg <= 1'b0;
            rx_byte_o <= BYTE_RESET;
            done_o    <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            sck_d_reg <= pin_s[2];
            shift_reg <= load_ok ? tx_byte : (fall ? shifted : shift_reg);
            samp_reg  <= rise ? in_bit : samp_reg;
            rx_byte_o <= last ? shifted : rx_byte_o;
            done_o    <= last;
            busy_o    <= state_next == SPIMS_RUN;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset | (~master_mode & pin_s[3])) begin
            bit_reg    <= 3'h0;
            active_reg <= 1'b0;
        end else begin
            bit_reg    <= fall ? bit_reg + 3'h1 : bit_reg;
            active_reg <= last ? 1'b0 : (rise | active_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins; as master the select line follows sel_n_req
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            spi.rem_sck_o   <= 1'b0;
            spi.rem_sck_oe  <= 1'b0;
            spi.rem_mosi_o  <= 1'b1;
            spi.rem_mosi_oe <= 1'b0;
            spi.rem_miso_o  <= 1'b1;
            spi.rem_miso_oe <= 1'b0;
            spi.rem_ss_o    <= 1'b1;
            spi.rem_ss_oe   <= 1'b0;
        end else begin
            spi.rem_sck_o   <= sck_reg;
            spi.rem_sck_oe  <= master_mode;
            spi.rem_mosi_o  <= out_bit;
            spi.rem_mosi_oe <= master_mode;
            spi.rem_miso_o  <= out_bit;
            spi.rem_miso_oe <= sel;
            spi.rem_ss_o    <= sel_n_req;
            spi.rem_ss_oe   <= master_mode;
        end
    end
endmodule

// ==== sim/spims_properties.sv ====
`timescale 1ns/10ps
module spims_properties (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_mosi_o,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic dev_ss_o,
    input wire logic dev_ss_oe,
    input wire logic ss_n
);
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    logic [2:0] rise_reg;
    wire        sck_rise = dev_sck_o && (hi_reg == 8'h00);

    // length of the current sck high and low phases, rises per byte
    always_ff @(posedge ref_clk) begin
        hi_reg   <= (reset || !dev_sck_o) ? 8'h00 : hi_reg + 8'h01;
        lo_reg   <= (reset || dev_sck_o) ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hFF};
        rise_reg <= (reset || !dev_sck_oe) ? 3'h0 : rise_reg + {2'h0, sck_rise};
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    property p_master_miso_in; dev_sck_oe |-> !dev_miso_oe; endproperty
    a_master_miso_in: assert property (p_master_miso_in) else $error("miso driven in master mode");
    property p_slave_pins_in; dev_miso_oe |-> !(dev_sck_oe || dev_mosi_oe || dev_ss_oe); endproperty
    a_slave_pins_in: assert property (p_slave_pins_in) else $error("slave drives an input pin");
    property p_desel_miso_off; ss_n [*4] |-> !dev_miso_oe; endproperty
    a_desel_miso_off: assert property (p_desel_miso_off) else $error("miso driven while deselected");
    property p_mosi_steady; dev_sck_oe && $rose(dev_sck_o) |-> $stable(dev_mosi_o); endproperty
    a_mosi_steady: assert property (p_mosi_steady) else $error("mosi moved at sck rise");
    property p_half_period;
        $fell(dev_sck_o) |-> hi_reg inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    endproperty
    a_half_period: assert property (p_half_period) else $error("sck half period off");
    property p_eight_rises; lo_reg == 8'h8C |-> rise_reg == 3'h0; endproperty
    a_eight_rises: assert property (p_eight_rises) else $error("byte not eight sck rises");
    property p_mode_fault; dev_sck_oe && !dev_ss_oe && !ss_n |-> ##[1:8] !dev_sck_oe; endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("select low kept master mode");
    property p_ss_software; dev_sck_oe && $rose(dev_sck_o) |-> $stable(dev_ss_o) && $stable(dev_ss_oe); endproperty
    a_ss_software: assert property (p_ss_software) else $error("select moved by hardware");

    c_slow_rate: cover property (hi_reg == 8'h40);
    c_slave_active: cover property (dev_miso_oe && !ss_n);
    c_master_dropped: cover property ($fell(dev_sck_oe));
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
    import spims_pkg::*;
    logic        ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic        master_mode, lsb_first, sel_n_req, start, busy_o, done_o;
    logic [3:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, cfg;
    logic [7:0]  tx_byte, rx_byte_o, hi_len, last_hi;
    logic [6:0]  half_tab [8] = '{HALF_R0, HALF_R1, HALF_R2, HALF_R3, HALF_D0, HALF_D1, HALF_D2, HALF_D3};
    int          failures, n_compared;

    spims_if bus ();
    spims_device spims_device_inst (.ref_clk(ref_clk), .reset(reset), .spi(bus.dev), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    spims_remote spims_remote_inst (.ref_clk(ref_clk), .reset(reset), .spi(bus.rem), .master_mode(master_mode),
        .lsb_first(lsb_first), .sel_n_req(sel_n_req), .start(start), .tx_byte(tx_byte), .busy_o(busy_o),
        .done_o(done_o), .rx_byte_o(rx_byte_o));
    spims_properties spims_properties_inst (.ref_clk(ref_clk), .reset(reset), .dev_sck_o(bus.dev_sck_o),
        .dev_sck_oe(bus.dev_sck_oe), .dev_mosi_o(bus.dev_mosi_o), .dev_mosi_oe(bus.dev_mosi_oe),
        .dev_miso_oe(bus.dev_miso_oe), .dev_ss_o(bus.dev_ss_o), .dev_ss_oe(bus.dev_ss_oe), .ss_n(bus.ss_n));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // length of the last device sck high phase
    always @(posedge ref_clk) begin
        hi_len <= bus.dev_sck_o ? hi_len + 8'h01 : 8'h00;
        if (!bus.dev_sck_o && hi_len != 8'h00) last_hi <= hi_len;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd_check(input string what, input logic [3:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic wait_busy;
        int n;
        n = 0;
        do begin
            wb(1'b0, STAT_OFS, 32'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 600);
        if (n >= 600) failures++;
    endtask

    task automatic rem_go(input logic [7:0] b);
        tx_byte <= b;
        start   <= 1'b1;
        @(posedge ref_clk);
        start   <= 1'b0;
    endtask

    task automatic wait_rem;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (done_o !== 1'b1 && n < 300);
        if (n >= 300) failures++;
        repeat (8) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // slowest byte is 1024 cycles; the whole run needs well under 400 us
    initial begin
        #400000;
        failures++;
        final_report;
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, master_mode, lsb_first, start} = 6'h00;
        {wb_adr_i, wb_dat_i, tx_byte, hi_len, last_hi} = '0;
        sel_n_req = 1'b1;
        reset = 1'b1;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        rd_check("ctrl reset", CTRL_OFS, {23'h0, CTRL_RESET});
        rd_check("status reset", STAT_OFS, 32'h0);
        wb(1'b1, 4'hC, 32'hFF);
        rd_check("unmapped read", 4'hC, 32'h0);
        rd_check("ctrl after unmapped write", CTRL_OFS, 32'h0);
        // device master, remote slave, every rate and both bit orders
        for (int r = 0; r < 8; r++) begin
            cfg = (32'h1 << CTRL_EN_BIT) | (32'h1 << CTRL_MASTER_SELECT_BIT_BIT) | (32'(r[0]) << CTRL_LSB_BIT)
                | (32'(r[1:0]) << CTRL_RATE_BIT) | (32'h1 << CTRL_IRQEN_BIT) | (32'(r[2]) << CTRL_DBL_BIT)
                | (32'h1 << CTRL_SSOE_BIT);
            lsb_first <= r[0];
            wb(1'b1, CTRL_OFS, cfg | (32'h1 << CTRL_SSOUT_BIT));
            rem_go(8'h5A ^ r[7:0]);
            wb(1'b1, CTRL_OFS, cfg);
            wb(1'b1, DATA_OFS, {24'h0, 8'h96 ^ r[7:0]});
            if (r == 1) wb(1'b1, DATA_OFS, 32'h11);
            wait_busy;
            check("sck half period", {24'h0, last_hi}, {25'h0, half_tab[r]});
            rd_check("status after byte", STAT_OFS, {30'h0, r == 1, 1'b1});
            check("irq after byte", {31'h0, irq_o}, 32'h1);
            wb(1'b0, DATA_OFS, 32'h0);
            if (half_tab[r] >= 7'h08) begin
                check("remote received", {24'h0, rx_byte_o}, {24'h0, 8'h96 ^ r[7:0]});
                check("device received", rd, {24'h0, 8'h5A ^ r[7:0]});
            end
        end
        // device slave, remote master
        wb(1'b1, CTRL_OFS, (32'h1 << CTRL_EN_BIT) | (32'h1 << CTRL_IRQEN_BIT));
        lsb_first   <= 1'b0;
        master_mode <= 1'b1;
        wb(1'b1, DATA_OFS, 32'h6E);
        rem_go(8'hFF);
        wait_rem;
        rd_check("deselected slave idle", STAT_OFS, 32'h0);
        sel_n_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rem_go(8'hC3);
        wait_rem;
        check("slave reply", {24'h0, rx_byte_o}, 32'h6E);
        check("remote idle after byte", {31'h0, busy_o}, 32'h0);
        rd_check("slave done", STAT_OFS, 32'h1);
        check("slave irq", {31'h0, irq_o}, 32'h1);
        wb(1'b1, DATA_OFS, 32'h2B);
        rd_check("rx kept after tx write", DATA_OFS, 32'hC3);
        rem_go(8'h44);
        @(posedge ref_clk);
        check("remote busy in byte", {31'h0, busy_o}, 32'h1);
        wait_rem;
        check("new slave reply", {24'h0, rx_byte_o}, 32'h2B);
        rem_go(8'h71);
        wait_rem;
        rd_check("unread byte overwritten", DATA_OFS, 32'h71);
        sel_n_req <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("miso released", {31'h0, bus.miso}, 32'h1);
        // select pulled low under a master whose select is an input
        wb(1'b1, CTRL_OFS, (32'h1 << CTRL_EN_BIT) | (32'h1 << CTRL_MASTER_SELECT_BIT_BIT));
        repeat (4) @(posedge ref_clk);
        rd_check("master kept while select high", CTRL_OFS, 32'h3);
        sel_n_req <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd_check("master bit cleared", CTRL_OFS, 32'h1);
        rd_check("fault sets done", STAT_OFS, 32'h1);
        check("irq masked without enable", {31'h0, irq_o}, 32'h0);
        sel_n_req <= 1'b1;
        final_report;
    end
endmodule
